// [pulse_pin_model.sv]
`timescale 1ns/100ps
// Signal sources and loads that sit on the eight pulse pins
module pulse_pin_model (
  // Device side of each pin
  input wire logic [7:0] pulse_outputs_zero_to_seven,
  input wire logic [7:0] pulse_oe,
  // Bench control of the external sources
  input wire logic [7:0] src_en,
  input wire logic [7:0] src_level,
  // Resolved level seen on each pin
  output logic [7:0] pin_level
);
  // Device wins while it drives; a released pin with no source enabled falls to its pull-down,
  // so a stale level can never pass for a real edge
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pulse_oe[i])
        pin_level[i] = pulse_outputs_zero_to_seven[i];
      else if (src_en[i])
        pin_level[i] = src_level[i];
      else
        pin_level[i] = 1'b0;
    end
  end
endmodule

// [pwm_capture_pkg.sv]
// Operation
// - Four generators, eight outputs or four pairs
// - 8-bit prescaler then divider 1..16
// - Per-channel 16-bit down counter and comparator
// - Counter reaching zero sets channel flag
// - Flag interrupts only when its zero interrupt enabled
// - Bit 4 pairs outputs 0 and 1
// - Pairs 2/3, 4/5, 6/7 likewise
// - Period and compare load at zero
// - Auto-reload restarts counter from period
// - One-shot stops at zero, one interrupt
// - Output goes high at compare match
// - Capture turns output pin into input
// - Edges latch counter into rise/fall latches
// - Separate rise and fall capture interrupt enables
// - Capture interrupt reloads channel counter
package pwm_capture_pkg;
  // Byte offsets of the register map
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CHAN_EN = 8'h04;
  localparam logic [7:0] OFS_RELOAD_MODE = 8'h08;
  localparam logic [7:0] OFS_PRESCALE = 8'h0C;
  localparam logic [7:0] OFS_DIVSEL = 8'h10;
  localparam logic [7:0] OFS_DEADTIME = 8'h14;
  localparam logic [7:0] OFS_ZERO_IE = 8'h18;
  localparam logic [7:0] OFS_PERIOD_BASE = 8'h20;
  localparam logic [7:0] OFS_COMPARE_BASE = 8'h40;
  localparam logic [7:0] OFS_IRQ_INDICATOR = 8'h60;
  localparam logic [7:0] OFS_CAP_STATUS = 8'h64;
  localparam logic [7:0] OFS_CAP_CTRL_BASE = 8'h68;
  localparam logic [7:0] OFS_RISE_LATCH_BASE = 8'h80;
  localparam logic [7:0] OFS_FALL_LATCH_BASE = 8'hA0;
  localparam logic [7:0] OFS_COUNTER_BASE = 8'hC0;
  // Field positions
  localparam int DZ_EN_LSB = 4;
  localparam int CAP_EN_BIT = 0;
  localparam int CAP_RISE_IE_BIT = 1;
  localparam int CAP_FALL_IE_BIT = 2;
  localparam int CAP_HI_CH_SHIFT = 16;
  localparam int FALL_FLAG_LSB = 8;
  // Reset values and the dead-zone count ceiling
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [2:0] DIVSEL_RESET = 3'h0;
  localparam logic [7:0] DEADTIME_RESET = 8'h00;
  localparam logic [7:0] DZ_CNT_MAX = 8'hFF;
  // Divider select codes
  localparam logic [2:0] DIV_BY_1 = 3'h0;
  localparam logic [2:0] DIV_BY_2 = 3'h1;
  localparam logic [2:0] DIV_BY_4 = 3'h2;
  localparam logic [2:0] DIV_BY_8 = 3'h3;
  localparam logic [2:0] DIV_BY_16 = 3'h4;
endpackage

// [pwm_capture_timer_group.sv]
`timescale 1ns/100ps
module pwm_capture_timer_group (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pulse pins, three signals each
  input wire logic [7:0] pulse_in,
  output logic [7:0] pulse_outputs_zero_to_seven,
  output logic [7:0] pulse_oe,
  // Interrupt
  output logic irq
);

  // Software configuration
  logic [3:0] dz_en_reg;            // One dead-zone enable per pair
  logic [7:0] chan_en_reg;          // Channel run enables
  logic [7:0] reload_mode_reg;      // 1 = auto-reload, 0 = one-shot
  logic [7:0] prescale_reg [4];     // Per generator prescaler
  logic [2:0] divsel_reg [4];       // Per generator divider code
  logic [7:0] deadtime_reg [4];     // Dead time in pclk cycles
  logic [7:0] zero_ie_reg;          // Period-zero interrupt enables
  logic [15:0] period_reload_reg [8];
  logic [15:0] cmp_buf_reg [8];     // Compare buffer, software side
  logic [2:0] cap_cfg_reg [8];      // {fall ie, rise ie, capture enable}
  // Status
  logic [7:0] zero_flag_reg;
  logic [7:0] rise_flag_reg;
  logic [7:0] fall_flag_reg;
  logic [15:0] rising_capture_latch [8];
  logic [15:0] falling_capture_latch [8];
  // Timer state
  logic [15:0] cnt_reg [8];
  logic [15:0] cmp_act_reg [8];
  logic [7:0] running_reg;
  logic [7:0] done_reg;
  logic [7:0] wave_reg;             // Raw waveform before dead zone
  logic [7:0] gen_tick;             // Divided tick per channel
  logic [7:0] zero_evt;
  logic [7:0] cap_en;
  logic [7:0] rise_evt;
  logic [7:0] fall_evt;
  logic [7:0] cap_irq_evt;
  // Pin synchronisers
  logic [7:0] in_meta_reg;
  logic [7:0] in_sync_reg;
  logic [7:0] in_prev_reg;
  // Bus decode and next pin data
  logic wr_en;
  logic rd_setup;
  logic [2:0] sub_idx;
  logic mapped;
  logic [31:0] rd_data;
  logic [7:0] zero_clr;
  logic [7:0] rise_clr;
  logic [7:0] fall_clr;
  logic [7:0] pin_next;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign sub_idx = paddr[4:2];
  assign pslverr = psel & penable & ~mapped;

  // Write-one-to-clear strobes for the sticky flags
  assign zero_clr = (wr_en && paddr == pwm_capture_pkg::OFS_IRQ_INDICATOR) ? pwdata[7:0] : 8'h00;
  assign rise_clr = (wr_en && paddr == pwm_capture_pkg::OFS_CAP_STATUS) ? pwdata[7:0] : 8'h00;
  assign fall_clr = (wr_en && paddr == pwm_capture_pkg::OFS_CAP_STATUS) ? pwdata[15:8] : 8'h00;

  // Read mux and address map check
  always_comb
  begin
    rd_data = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr[7:5])
      3'h0:
      begin
        case (paddr[4:0])
          5'h00: rd_data[7:4] = dz_en_reg;
          5'h04: rd_data[7:0] = chan_en_reg;
          5'h08: rd_data[7:0] = reload_mode_reg;
          5'h0C: rd_data = {prescale_reg[3], prescale_reg[2], prescale_reg[1], prescale_reg[0]};
          5'h10: rd_data[15:0] = {1'b0, divsel_reg[3], 1'b0, divsel_reg[2], 1'b0, divsel_reg[1],
                                  1'b0, divsel_reg[0]};
          5'h14: rd_data = {deadtime_reg[3], deadtime_reg[2], deadtime_reg[1], deadtime_reg[0]};
          5'h18: rd_data[7:0] = zero_ie_reg;
          default: mapped = 1'b0;
        endcase
      end
      3'h1: rd_data[15:0] = period_reload_reg[sub_idx];
      3'h2: rd_data[15:0] = cmp_buf_reg[sub_idx];
      3'h3:
      begin
        // Indicator, capture status, then the four capture control words
        if (paddr[4:0] == 5'h00)
          rd_data[7:0] = zero_flag_reg;
        else if (paddr[4:0] == 5'h04)
          rd_data[15:0] = {fall_flag_reg, rise_flag_reg};
        else if (paddr[4:0] >= 5'h08 && paddr[4:0] <= 5'h14)
        begin
          rd_data[2:0] = cap_cfg_reg[{sub_idx[1:0] - 2'h2, 1'b0}];
          rd_data[18:16] = cap_cfg_reg[{sub_idx[1:0] - 2'h2, 1'b1}];
        end
        else
          mapped = 1'b0;
      end
      3'h4: rd_data[15:0] = rising_capture_latch[sub_idx];
      3'h5: rd_data[15:0] = falling_capture_latch[sub_idx];
      3'h6: rd_data[15:0] = cnt_reg[sub_idx];
      default: mapped = 1'b0;
    endcase
  end

  // Read data is registered in the setup cycle, ready at the access edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= rd_data;
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dz_en_reg <= 4'h0;
      chan_en_reg <= 8'h00;
      reload_mode_reg <= 8'h00;
      zero_ie_reg <= 8'h00;
      for (int k = 0; k < 4; k++)
      begin
        prescale_reg[k] <= pwm_capture_pkg::PRESCALE_RESET;
        divsel_reg[k] <= pwm_capture_pkg::DIVSEL_RESET;
        deadtime_reg[k] <= pwm_capture_pkg::DEADTIME_RESET;
      end
      for (int k = 0; k < 8; k++)
      begin
        period_reload_reg[k] <= pwm_capture_pkg::PERIOD_RESET;
        cmp_buf_reg[k] <= pwm_capture_pkg::COMPARE_RESET;
        cap_cfg_reg[k] <= 3'h0;
      end
    end
    else if (wr_en)
    begin
      if (paddr == pwm_capture_pkg::OFS_CONTROL)
        dz_en_reg <= pwdata[pwm_capture_pkg::DZ_EN_LSB +: 4];
      if (paddr == pwm_capture_pkg::OFS_CHAN_EN)
        chan_en_reg <= pwdata[7:0];
      if (paddr == pwm_capture_pkg::OFS_RELOAD_MODE)
        reload_mode_reg <= pwdata[7:0];
      if (paddr == pwm_capture_pkg::OFS_ZERO_IE)
        zero_ie_reg <= pwdata[7:0];
      for (int k = 0; k < 4; k++)
      begin
        if (paddr == pwm_capture_pkg::OFS_PRESCALE)
          prescale_reg[k] <= pwdata[8*k +: 8];
        if (paddr == pwm_capture_pkg::OFS_DIVSEL)
          divsel_reg[k] <= pwdata[4*k +: 3];
        if (paddr == pwm_capture_pkg::OFS_DEADTIME)
          deadtime_reg[k] <= pwdata[8*k +: 8];
        // Two channels per capture control word
        if (paddr == pwm_capture_pkg::OFS_CAP_CTRL_BASE + 8'(4 * k))
        begin
          cap_cfg_reg[2*k] <= pwdata[2:0];
          cap_cfg_reg[2*k+1] <= pwdata[pwm_capture_pkg::CAP_HI_CH_SHIFT +: 3];
        end
      end
      // Software only ever touches the buffers, never the live timer
      if (paddr[7:5] == 3'h1)
        period_reload_reg[sub_idx] <= pwdata[15:0];
      if (paddr[7:5] == 3'h2)
        cmp_buf_reg[sub_idx] <= pwdata[15:0];
    end
  end

  // Pin inputs pass two flip-flops, a third keeps the previous level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_meta_reg <= 8'h00;
      in_sync_reg <= 8'h00;
      in_prev_reg <= 8'h00;
    end
    else
    begin
      in_meta_reg <= pulse_in;
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  // Sticky flags: a new event wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zero_flag_reg <= 8'h00;
      rise_flag_reg <= 8'h00;
      fall_flag_reg <= 8'h00;
    end
    else
    begin
      zero_flag_reg <= (zero_flag_reg & ~zero_clr) | zero_evt;
      rise_flag_reg <= (rise_flag_reg & ~rise_clr) | rise_evt;
      fall_flag_reg <= (fall_flag_reg & ~fall_clr) | fall_evt;
    end
  end

  // One level output for every enabled source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(zero_flag_reg & zero_ie_reg) | |(rise_flag_reg & cap_rise_ie()) |
             |(fall_flag_reg & cap_fall_ie());
  end

  function automatic logic [7:0] cap_rise_ie();
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 8; k++)
      v[k] = cap_cfg_reg[k][pwm_capture_pkg::CAP_RISE_IE_BIT];
    return v;
  endfunction

  function automatic logic [7:0] cap_fall_ie();
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 8; k++)
      v[k] = cap_cfg_reg[k][pwm_capture_pkg::CAP_FALL_IE_BIT];
    return v;
  endfunction

  // Prescaler and divider, shared by the two channels of a generator
  for (genvar g = 0; g < 4; g++)
  begin : gen_clk
    logic [7:0] pre_cnt_reg;
    logic [3:0] div_cnt_reg;
    logic [3:0] div_mask;
    logic pre_tick;
    assign pre_tick = (pre_cnt_reg == prescale_reg[g]);
    always_comb
    begin
      case (divsel_reg[g])
        pwm_capture_pkg::DIV_BY_2: div_mask = 4'h1;
        pwm_capture_pkg::DIV_BY_4: div_mask = 4'h3;
        pwm_capture_pkg::DIV_BY_8: div_mask = 4'h7;
        pwm_capture_pkg::DIV_BY_16: div_mask = 4'hF;
        default: div_mask = 4'h0;
      endcase
    end
    // Divide by prescale + 1, then by the selected power of two
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pre_cnt_reg <= 8'h00;
        div_cnt_reg <= 4'h0;
      end
      else if (pre_tick)
      begin
        pre_cnt_reg <= 8'h00;
        div_cnt_reg <= div_cnt_reg + 4'h1;
      end
      else
        pre_cnt_reg <= pre_cnt_reg + 8'h01;
    end
    assign gen_tick[2*g] = pre_tick && ((div_cnt_reg & div_mask) == div_mask);
    assign gen_tick[2*g+1] = gen_tick[2*g];
  end

  // Per-channel timer, comparator and capture
  for (genvar i = 0; i < 8; i++)
  begin : gen_ch
    logic [15:0] cnt_m1;
    assign cnt_m1 = cnt_reg[i] - 16'h0001;
    assign cap_en[i] = cap_cfg_reg[i][pwm_capture_pkg::CAP_EN_BIT];
    assign rise_evt[i] = cap_en[i] & in_sync_reg[i] & ~in_prev_reg[i];
    assign fall_evt[i] = cap_en[i] & ~in_sync_reg[i] & in_prev_reg[i];
    assign cap_irq_evt[i] = (rise_evt[i] & cap_cfg_reg[i][pwm_capture_pkg::CAP_RISE_IE_BIT]) |
                            (fall_evt[i] & cap_cfg_reg[i][pwm_capture_pkg::CAP_FALL_IE_BIT]);
    assign zero_evt[i] = running_reg[i] & gen_tick[i] & (cnt_reg[i] == 16'h0000);

    // Down counter; disabling a channel parks it with fresh buffers
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        cnt_reg[i] <= 16'h0000;
        cmp_act_reg[i] <= 16'h0000;
        running_reg[i] <= 1'b0;
        done_reg[i] <= 1'b0;
        wave_reg[i] <= 1'b0;
      end
      else if (!chan_en_reg[i])
      begin
        cnt_reg[i] <= period_reload_reg[i];
        cmp_act_reg[i] <= cmp_buf_reg[i];
        running_reg[i] <= 1'b0;
        done_reg[i] <= 1'b0;
        wave_reg[i] <= 1'b0;
      end
      else if (cap_irq_evt[i])
        cnt_reg[i] <= period_reload_reg[i];
      else if (!running_reg[i] && !done_reg[i])
        running_reg[i] <= 1'b1;
      else if (zero_evt[i])
      begin
        cmp_act_reg[i] <= cmp_buf_reg[i];
        wave_reg[i] <= 1'b0;
        if (reload_mode_reg[i])
          cnt_reg[i] <= period_reload_reg[i];
        else
        begin
          running_reg[i] <= 1'b0;
          done_reg[i] <= 1'b1;
        end
      end
      else if (running_reg[i] && gen_tick[i])
      begin
        cnt_reg[i] <= cnt_m1;
        if (cnt_m1 == cmp_act_reg[i])
          wave_reg[i] <= 1'b1;
      end
    end

    // Edges copy the live counter into the latches
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        rising_capture_latch[i] <= 16'h0000;
        falling_capture_latch[i] <= 16'h0000;
      end
      else
      begin
        if (rise_evt[i])
          rising_capture_latch[i] <= cnt_reg[i];
        if (fall_evt[i])
          falling_capture_latch[i] <= cnt_reg[i];
      end
    end

    // Output drivers are released while the pin captures
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        pulse_oe[i] <= 1'b0;
      else
        pulse_oe[i] <= chan_en_reg[i] & ~cap_en[i];
    end

    property p_zero_flag;
      @(posedge pclk) disable iff (!presetn)
      zero_evt[i] |=> zero_flag_reg[i];
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag not set");
    property p_reload;
      @(posedge pclk) disable iff (!presetn)
      zero_evt[i] && reload_mode_reg[i] && !cap_irq_evt[i] && chan_en_reg[i]
      |=> cnt_reg[i] == $past(period_reload_reg[i]);
    endproperty
    a_reload: assert property (p_reload) else $error("auto-reload value wrong");
    property p_oneshot;
      @(posedge pclk) disable iff (!presetn)
      zero_evt[i] && !reload_mode_reg[i] && !cap_irq_evt[i] && chan_en_reg[i]
      |=> !running_reg[i] ##1 !zero_evt[i];
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");
    property p_rise_latch;
      @(posedge pclk) disable iff (!presetn)
      rise_evt[i] |=> rising_capture_latch[i] == $past(cnt_reg[i]);
    endproperty
    a_rise_latch: assert property (p_rise_latch) else $error("rising latch wrong");
    property p_cap_pin;
      @(posedge pclk) disable iff (!presetn)
      cap_en[i] |=> !pulse_oe[i];
    endproperty
    a_cap_pin: assert property (p_cap_pin) else $error("capture pin still driven");
  end

  // Dead-zone generators, one per pair, driven by the even timer
  for (genvar p = 0; p < 4; p++)
  begin : gen_dz
    logic base_prev_reg;
    logic [7:0] dz_cnt_reg;
    logic settled;
    // The pin register adds the last cycle of the dead time, so the count
    // only has to reach dead time less one; a zero dead time still costs a cycle
    assign settled = ({1'b0, dz_cnt_reg} + 9'h001 >= {1'b0, deadtime_reg[p]});
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        base_prev_reg <= 1'b0;
        dz_cnt_reg <= 8'h00;
      end
      else
      begin
        base_prev_reg <= wave_reg[2*p];
        if (wave_reg[2*p] != base_prev_reg)
          dz_cnt_reg <= 8'h00;
        else if (dz_cnt_reg != pwm_capture_pkg::DZ_CNT_MAX)
          dz_cnt_reg <= dz_cnt_reg + 8'h01;
      end
    end
    // Both legs go low at once; each rise waits out the dead time
    always_comb
    begin
      if (dz_en_reg[p])
      begin
        pin_next[2*p] = base_prev_reg & wave_reg[2*p] & settled;
        pin_next[2*p+1] = ~base_prev_reg & ~wave_reg[2*p] & settled;
      end
      else
      begin
        pin_next[2*p] = wave_reg[2*p];
        pin_next[2*p+1] = wave_reg[2*p+1];
      end
    end
  end

  // Registered pin data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_outputs_zero_to_seven <= 8'h00;
    else
      pulse_outputs_zero_to_seven <= pin_next;
  end

  property p_pair_excl;
    @(posedge pclk) disable iff (!presetn)
    $past(dz_en_reg[0]) |-> !(pulse_outputs_zero_to_seven[0] && pulse_outputs_zero_to_seven[1]);
  endproperty
  a_pair_excl: assert property (p_pair_excl) else $error("pair 0 legs both high");
  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
    (zero_flag_reg == 8'h01) && !zero_ie_reg[0] && rise_flag_reg == 8'h00 && fall_flag_reg == 8'h00
    |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked flag raised irq");
  property p_cmp_load;
    @(posedge pclk) disable iff (!presetn)
    chan_en_reg[0] && $past(chan_en_reg[0]) && $changed(cmp_act_reg[0]) |-> $past(zero_evt[0]);
  endproperty
  a_cmp_load: assert property (p_cmp_load) else $error("compare loaded outside zero");
  property p_match_high;
    @(posedge pclk) disable iff (!presetn)
    $rose(wave_reg[0]) |-> $past(cnt_reg[0]) == $past(cmp_act_reg[0]) + 16'h0001;
  endproperty
  a_match_high: assert property (p_match_high) else $error("output rose off compare");

  c_zero: cover property (@(posedge pclk) disable iff (!presetn) zero_evt[0] ##1 irq);
  c_capture: cover property (@(posedge pclk) disable iff (!presetn) rise_evt[3] ##[1:50] fall_evt[3]);
  c_pair: cover property (@(posedge pclk) disable iff (!presetn)
    dz_en_reg[0] && $rose(pulse_outputs_zero_to_seven[1]));
  c_oneshot: cover property (@(posedge pclk) disable iff (!presetn) $rose(done_reg[1]));

endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  // Clock, reset and bus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  // Pins and sources
  logic [7:0] src_en = 8'h00;
  logic [7:0] src_level = 8'h00;
  logic [7:0] pin_level;
  logic [7:0] pouts;
  logic [7:0] poe;
  // Bookkeeping
  int n_mismatch = 0;
  int check_count = 0;
  logic [32:0] exp_q[$];

  // 125 MHz clock
  always #4 pclk = ~pclk;

  pwm_capture_timer_group pwm_capture_timer_group_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_in(pin_level), .pulse_outputs_zero_to_seven(pouts), .pulse_oe(poe), .irq(irq)
  );

  pulse_pin_model pulse_pin_model_inst (
    .pulse_outputs_zero_to_seven(pouts), .pulse_oe(poe), .src_en(src_en),
    .src_level(src_level), .pin_level(pin_level)
  );

  // Compare one value and count it
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single place where the run ends
  task automatic give_verdict;
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A wait that ran out counts against the run
  task automatic time_out(input string what);
    n_mismatch++;
    $display("ERROR %s expected event seen timeout", what);
    give_verdict();
  endtask

  // One bus transfer; a read notes its expected data and error flag
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err = 1'b0);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      exp_q.push_back({err, d});
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 50)
        time_out("pready");
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Watcher: takes the oldest note whenever read data is handed over
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read data", {pslverr, prdata}, exp_q.pop_front());
  end

  // Count edges until a pin shows the wanted level
  task automatic wait_pin(input int ch, input logic lvl, output int cyc);
    cyc = 0;
    while (pouts[ch] !== lvl)
    begin
      @(posedge pclk);
      cyc++;
      if (cyc > 20000)
        time_out("pin level");
    end
  endtask

  initial
  begin
    int p, c, pre, d, hi, lo, gap, bad, ch;
    void'($urandom(32'h9aba4079));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Quiet pins and registers after reset; an unmapped place is refused
    check("pins after reset", {irq, pouts, poe}, 33'h0);
    apb(1'b0, pwm_capture_pkg::OFS_CONTROL, 32'h0);
    apb(1'b0, pwm_capture_pkg::OFS_PERIOD_BASE, 32'h0);
    apb(1'b0, pwm_capture_pkg::OFS_CAP_STATUS, 32'h0);
    apb(1'b0, 8'h1C, 32'h0, 1'b1);
    // One-shot on channel 1: one zero flag, masked until enabled
    apb(1'b1, pwm_capture_pkg::OFS_PERIOD_BASE + 8'h04, 32'h3);
    apb(1'b1, pwm_capture_pkg::OFS_COMPARE_BASE + 8'h04, 32'h1);
    apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h2);
    repeat (20) @(posedge pclk);
    apb(1'b0, pwm_capture_pkg::OFS_IRQ_INDICATOR, 32'h2);
    check("masked irq", irq, 1'b0);
    apb(1'b1, pwm_capture_pkg::OFS_ZERO_IE, 32'h2);
    repeat (3) @(posedge pclk);
    check("enabled irq", irq, 1'b1);
    apb(1'b1, pwm_capture_pkg::OFS_IRQ_INDICATOR, 32'h2);
    repeat (20) @(posedge pclk);
    apb(1'b0, pwm_capture_pkg::OFS_IRQ_INDICATOR, 32'h0);
    apb(1'b0, pwm_capture_pkg::OFS_COUNTER_BASE + 8'h04, 32'h0);
    check("irq after clear", irq, 1'b0);
    apb(1'b1, pwm_capture_pkg::OFS_ZERO_IE, 32'h0);
    apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h0);
    // Auto-reload on channel 0 through every divider code
    for (int k = 0; k < 5; k++)
    begin
      p = 4 + $urandom % 12;
      c = $urandom % p;
      pre = $urandom % 4;
      apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h0);
      apb(1'b1, pwm_capture_pkg::OFS_PERIOD_BASE, 32'(p));
      apb(1'b1, pwm_capture_pkg::OFS_COMPARE_BASE, 32'(c));
      apb(1'b1, pwm_capture_pkg::OFS_RELOAD_MODE, 32'h1);
      apb(1'b1, pwm_capture_pkg::OFS_PRESCALE, 32'(pre));
      apb(1'b1, pwm_capture_pkg::OFS_DIVSEL, 32'(k));
      apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h1);
      wait_pin(0, 1'b1, hi);
      wait_pin(0, 1'b0, hi);
      wait_pin(0, 1'b1, lo);
      wait_pin(0, 1'b0, hi);
      wait_pin(0, 1'b1, lo);
      check("high width", hi, (c + 1) * (pre + 1) << k);
      check("period", hi + lo, (p + 1) * (pre + 1) << k);
    end
    apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h0);
    apb(1'b1, pwm_capture_pkg::OFS_PRESCALE, 32'h0);
    apb(1'b1, pwm_capture_pkg::OFS_DIVSEL, 32'h0);
    // Each complementary pair with its own dead time
    for (int q = 0; q < 4; q++)
    begin
      ch = 2 * q;
      d = 1 + $urandom % 5;
      apb(1'b1, pwm_capture_pkg::OFS_PERIOD_BASE + 8'(4 * ch), 32'd20);
      apb(1'b1, pwm_capture_pkg::OFS_COMPARE_BASE + 8'(4 * ch), 32'd8);
      apb(1'b1, pwm_capture_pkg::OFS_RELOAD_MODE, 32'(1 << ch));
      apb(1'b1, pwm_capture_pkg::OFS_DEADTIME, 32'(d << (8 * q)));
      apb(1'b1, pwm_capture_pkg::OFS_CONTROL, 32'(1 << (4 + q)));
      apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'(3 << ch));
      wait_pin(ch, 1'b1, gap);
      wait_pin(ch, 1'b0, gap);
      wait_pin(ch + 1, 1'b1, gap);
      check("dead time", gap, d);
      bad = 0;
      repeat (60)
      begin
        @(posedge pclk);
        if (pouts[ch] && pouts[ch + 1])
          bad++;
      end
      check("pair overlap", bad, 0);
      apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h0);
      apb(1'b1, pwm_capture_pkg::OFS_CONTROL, 32'h0);
    end
    apb(1'b1, pwm_capture_pkg::OFS_IRQ_INDICATOR, 32'hFF);
    // Capture on channel 3: timer first, then capture with rise interrupt
    apb(1'b1, pwm_capture_pkg::OFS_PERIOD_BASE + 8'h0C, 32'h0FFF);
    apb(1'b1, pwm_capture_pkg::OFS_RELOAD_MODE, 32'h8);
    apb(1'b1, pwm_capture_pkg::OFS_CHAN_EN, 32'h8);
    apb(1'b1, pwm_capture_pkg::OFS_CAP_CTRL_BASE + 8'h04, 32'h00030000);
    repeat (5) @(posedge pclk);
    check("capture pin released", poe[3], 1'b0);
    src_en <= 8'h08;
    repeat (10) @(posedge pclk);
    src_level <= 8'h08;
    repeat (40) @(posedge pclk);
    src_level <= 8'h00;
    repeat (10) @(posedge pclk);
    apb(1'b0, pwm_capture_pkg::OFS_CAP_STATUS, 32'h0808);
    check("capture irq", irq, 1'b1);
    apb(1'b0, pwm_capture_pkg::OFS_FALL_LATCH_BASE + 8'h0C, 32'h0FFF - 32'd39);
    apb(1'b1, pwm_capture_pkg::OFS_CAP_STATUS, 32'h0008);
    repeat (3) @(posedge pclk);
    check("fall flag masked", irq, 1'b0);
    apb(1'b0, pwm_capture_pkg::OFS_CAP_STATUS, 32'h0800);
    // Fall interrupt enable alone now lets the standing fall flag through
    apb(1'b1, pwm_capture_pkg::OFS_CAP_CTRL_BASE + 8'h04, 32'h00050000);
    repeat (3) @(posedge pclk);
    check("fall irq", irq, 1'b1);
    give_verdict();
  end
endmodule
